// ### core/ecg_port_consts.vh
// Purpose : shared constants of the ECG frame master serial port
// Assumes : core clock of 20 MHz
// Notes   : times are kept in picoseconds, cycle counts derive from them
`ifndef ECG_PORT_CONSTS_VH
`define ECG_PORT_CONSTS_VH

`define CORE_CLK_HZ          20000000
`define CORE_CLK_PERIOD_PS   50000
`define FRAME_RATE_HZ        128000
`define CS_SETUP_PS          24400
`define CS_HOLD_PS           48800
`define FRAME_GAP_WHOLE_PS   2173000
`define FRAME_GAP_WORD_PS    2026000

`define CEIL_CYC(ps)         (((ps) + `CORE_CLK_PERIOD_PS - 1) / `CORE_CLK_PERIOD_PS)
`define FRAME_CYCLES         (`CORE_CLK_HZ / `FRAME_RATE_HZ)
`define CS_SETUP_CYCLES      `CEIL_CYC(`CS_SETUP_PS)
`define CS_HOLD_CYCLES       `CEIL_CYC(`CS_HOLD_PS)
`define FRAME_GAP_WHOLE_CYC  `CEIL_CYC(`FRAME_GAP_WHOLE_PS)
`define FRAME_GAP_WORD_CYC   `CEIL_CYC(`FRAME_GAP_WORD_PS)
`define WORD_GAP_CYCLES      2

`define WORD_BITS            16
`define FRAME_WORDS          7
`define LAST_WORD_INDEX      3'h6
`define LAST_BIT_INDEX       4'hF
`define HEADER_INDEX         3'h0
`define CRC_INDEX            3'h6

`endif

// ### core/frame_word_store.v
// Purpose : holds the seven words of one frame, read data from a register
// Assumes : single clock, synchronous write
// Notes   : index 0 header, 1..5 ECG words, 6 CRC
`timescale 1ns/10ps
`include "ecg_port_consts.vh"

module frame_word_store (
  input  wire        core_clk,
  input  wire        writeEnable,
  input  wire [2:0]  writeAddr,
  input  wire [15:0] writeData,
  input  wire [2:0]  readAddr,
  output reg  [15:0] readData
);

  reg [15:0] wordMem [0:7];

  always @(posedge core_clk) begin
    if (writeEnable) begin
      wordMem[writeAddr] <= writeData;
    end
    readData <= wordMem[readAddr];
  end

endmodule

// ### core/ecg_frame_master_serial_port.v
// Purpose : streams each ECG frame out as bus master on a three-wire port
// Assumes : word writes and mode inputs come from logic on core_clk
// Notes   : serial clock is core_clk divided by two, the fastest this clock allows
`timescale 1ns/10ps
`include "ecg_port_consts.vh"

// Notes on behaviour
// - device drives select, clock and data
// - frames start on a 128 kHz tick
// - frames start only with high-performance mode set
// - serial clock derived from own clock
// - data changes on serial clock rising edge
// - select leads clocking, held after last edge
// - whole-frame select, long gap between frames
// - per-word select, shorter gap between frames
// - per-word select: clock stays high four core cycles between words
// - header, five ECG words, CRC in order
module ecg_frame_master_serial_port (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        highPerfMode,
  input  wire        perWordSelectOption,
  input  wire        wordWrite,
  input  wire [2:0]  wordIndex,
  input  wire [15:0] wordData,
  output reg         port_chip_select_n,
  output reg         port_serial_clock,
  output reg         port_serial_data_out,
  output reg         frameBusy
);

  // ---------------------------------------------------------------
  // states and constants
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_SETUP    = 3'h1;
  localparam [2:0] ST_LOW      = 3'h2;
  localparam [2:0] ST_HIGH     = 3'h3;
  localparam [2:0] ST_HOLD     = 3'h4;
  localparam [2:0] ST_WORDGAP  = 3'h5;
  localparam [2:0] ST_FRAMEGAP = 3'h6;

  // counts are worked out as integers and cut to the counter width on purpose
  localparam integer FRAME_LAST_I = `FRAME_CYCLES - 1;
  localparam integer SETUP_I      = `CS_SETUP_CYCLES;
  localparam integer HOLD_I       = `CS_HOLD_CYCLES;
  localparam integer GAP_WHOLE_I  = `FRAME_GAP_WHOLE_CYC;
  localparam integer GAP_WORD_I   = `FRAME_GAP_WORD_CYC;
  localparam integer WGAP_I       = `WORD_GAP_CYCLES;

  localparam [7:0] FRAME_LAST  = FRAME_LAST_I[7:0];
  localparam [7:0] SETUP_CYC   = SETUP_I[7:0];
  localparam [7:0] HOLD_CYC    = HOLD_I[7:0];
  localparam [7:0] GAP_WHOLE   = GAP_WHOLE_I[7:0];
  localparam [7:0] GAP_WORD    = GAP_WORD_I[7:0];
  localparam [7:0] WGAP_CYC    = WGAP_I[7:0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [2:0]  state_reg,   state_next;
  reg [7:0]  tick_reg,    tick_next;
  reg        pending_reg, pending_next;
  reg [7:0]  wait_reg,    wait_next;
  reg [3:0]  bit_reg,     bit_next;
  reg [2:0]  word_reg,    word_next;
  reg [14:0] shift_reg,   shift_next;
  reg        csn_next;
  reg        sclk_next;
  reg        sdo_next;

  wire [15:0] fetchedWord;
  wire [2:0]  fetchAddr;
  wire        lastWord;
  wire        tickHit;

  // outside idle the store is addressed with the word after the one on the wire, so the
  // next MSB is ready at the rising edge that ends the current word
  assign fetchAddr = (state_next == ST_IDLE) ? `HEADER_INDEX : word_next + 3'h1;
  assign lastWord  = (word_reg == `LAST_WORD_INDEX);
  assign tickHit   = (tick_reg == FRAME_LAST);

  frame_word_store wordStore (
    .core_clk    (core_clk),
    .writeEnable (wordWrite),
    .writeAddr   (wordIndex),
    .writeData   (wordData),
    .readAddr    (fetchAddr),
    .readData    (fetchedWord)
  );

  // ---------------------------------------------------------------
  // frame tick and sequencer
  // ---------------------------------------------------------------
  always @* begin
    state_next   = state_reg;
    wait_next    = wait_reg;
    bit_next     = bit_reg;
    word_next    = word_reg;
    shift_next   = shift_reg;
    csn_next     = port_chip_select_n;
    sclk_next    = port_serial_clock;
    sdo_next     = port_serial_data_out;
    tick_next    = tickHit ? 8'h00 : tick_reg + 8'h01;
    pending_next = pending_reg | tickHit;

    case (state_reg)
      ST_IDLE: begin
        sclk_next = 1'b1;
        csn_next  = 1'b1;
        word_next = 3'h0;
        // a tick landing on the clearing edge is kept: the set wins
        if (!highPerfMode) begin
          pending_next = tickHit;
        end else if (pending_reg) begin
          pending_next = tickHit;
          csn_next     = 1'b0;
          sdo_next     = fetchedWord[15];
          shift_next   = fetchedWord[14:0];
          bit_next     = 4'h0;
          wait_next    = SETUP_CYC;
          state_next   = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // select leads the first falling edge by the setup time
        if (wait_reg <= 8'h01) begin
          sclk_next  = 1'b0;
          state_next = ST_LOW;
        end else begin
          wait_next = wait_reg - 8'h01;
        end
      end
      ST_LOW: begin
        sclk_next = 1'b1;
        if (bit_reg != `LAST_BIT_INDEX) begin
          sdo_next   = shift_reg[14];
          shift_next = {shift_reg[13:0], 1'b0};
          bit_next   = bit_reg + 4'h1;
          state_next = ST_HIGH;
        end else if (lastWord || perWordSelectOption) begin
          wait_next  = HOLD_CYC;
          state_next = ST_HOLD;
        end else begin
          // whole-frame select: next word follows with no clock gap
          sdo_next   = fetchedWord[15];
          shift_next = fetchedWord[14:0];
          bit_next   = 4'h0;
          word_next  = word_reg + 3'h1;
          state_next = ST_HIGH;
        end
      end
      ST_HIGH: begin
        sclk_next  = 1'b0;
        state_next = ST_LOW;
      end
      ST_HOLD: begin
        if (wait_reg <= 8'h01) begin
          csn_next = 1'b1;
          if (lastWord) begin
            wait_next  = perWordSelectOption ? GAP_WORD : GAP_WHOLE;
            state_next = ST_FRAMEGAP;
          end else begin
            wait_next  = WGAP_CYC;
            state_next = ST_WORDGAP;
          end
        end else begin
          wait_next = wait_reg - 8'h01;
        end
      end
      ST_WORDGAP: begin
        // clock parked high for two serial clock periods between words
        if (wait_reg <= 8'h01) begin
          csn_next   = 1'b0;
          sdo_next   = fetchedWord[15];
          shift_next = fetchedWord[14:0];
          bit_next   = 4'h0;
          word_next  = word_reg + 3'h1;
          wait_next  = SETUP_CYC;
          state_next = ST_SETUP;
        end else begin
          wait_next = wait_reg - 8'h01;
        end
      end
      ST_FRAMEGAP: begin
        // ticks that land during a frame collapse into one pending start
        if (wait_reg <= 8'h01) begin
          state_next = ST_IDLE;
        end else begin
          wait_next = wait_reg - 8'h01;
        end
      end
      default: begin
        state_next = ST_IDLE;
        csn_next   = 1'b1;
        sclk_next  = 1'b1;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      state_reg            <= ST_IDLE;
      tick_reg             <= 8'h00;
      pending_reg          <= 1'b0;
      wait_reg             <= 8'h00;
      bit_reg              <= 4'h0;
      word_reg             <= 3'h0;
      shift_reg            <= 15'h0000;
      port_chip_select_n   <= 1'b1;
      port_serial_clock    <= 1'b1;
      port_serial_data_out <= 1'b0;
      frameBusy            <= 1'b0;
    end else begin
      state_reg            <= state_next;
      tick_reg             <= tick_next;
      pending_reg          <= pending_next;
      wait_reg             <= wait_next;
      bit_reg              <= bit_next;
      word_reg             <= word_next;
      shift_reg            <= shift_next;
      port_chip_select_n   <= csn_next;
      port_serial_clock    <= sclk_next;
      port_serial_data_out <= sdo_next;
      frameBusy            <= (state_next != ST_IDLE);
    end
  end

endmodule

// ### verification/ecg_port_props.sv
// Purpose: timing checks on the serial port outputs
// Assumes: gaps of 44 (whole frame) and 41 (per word) core cycles
// Notes: gap counter resets to full so the first frame passes
`timescale 1ns/10ps
module ecg_port_props (
  input wire core_clk,
  input wire resetn,
  input wire highPerfMode,
  input wire perWordSelectOption,
  input wire port_chip_select_n,
  input wire port_serial_clock,
  input wire port_serial_data_out,
  input wire frameBusy
);
  reg [7:0] hiLen_reg;
  reg [7:0] falls_reg;
  reg       sclkPrev_reg;
  always @(posedge core_clk) begin
    sclkPrev_reg <= port_serial_clock;
    if (!resetn) begin
      hiLen_reg <= 8'hFF;
      falls_reg <= 8'h00;
    end else begin
      hiLen_reg <= !port_chip_select_n ? 8'h00 : hiLen_reg + {7'h00, hiLen_reg != 8'hFF};
      falls_reg <= port_chip_select_n ? 8'h00 : falls_reg + {7'h00, sclkPrev_reg & !port_serial_clock};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_setup; port_serial_clock ##1 !port_serial_clock; endsequence
  property p_idle; port_chip_select_n |-> port_serial_clock; endproperty
  property p_setup; $fell(port_chip_select_n) |-> s_setup; endproperty
  property p_hold; !perWordSelectOption && $rose(port_chip_select_n) |->
    $past(port_serial_clock) && !$past(port_serial_clock, 2); endproperty
  property p_data; !port_chip_select_n && $changed(port_serial_data_out) |->
    $rose(port_serial_clock) || $fell(port_chip_select_n); endproperty
  property p_period; $fell(port_serial_clock) |=> port_serial_clock; endproperty
  property p_hpm; !highPerfMode && !frameBusy |=> port_chip_select_n; endproperty
  property p_gap; $fell(port_chip_select_n) && !$past(frameBusy) |->
    hiLen_reg >= (perWordSelectOption ? 8'h29 : 8'h2C); endproperty
  property p_wgap; perWordSelectOption && $fell(port_chip_select_n) && $past(frameBusy) |->
    hiLen_reg >= 8'h02 && hiLen_reg <= 8'h03; endproperty
  property p_bits; $rose(port_chip_select_n) |-> falls_reg == (perWordSelectOption ? 8'h10 : 8'h70); endproperty
  a_idle: assert property (p_idle) else $error("clock low while deselected");
  a_setup: assert property (p_setup) else $error("no setup cycle");
  a_hold: assert property (p_hold) else $error("bad select hold");
  a_data: assert property (p_data) else $error("data moved off rising edge");
  a_period: assert property (p_period) else $error("clock low too long");
  a_hpm: assert property (p_hpm) else $error("frame without mode bit");
  a_gap: assert property (p_gap) else $error("frame gap short");
  a_wgap: assert property (p_wgap) else $error("word gap wrong");
  a_bits: assert property (p_bits) else $error("wrong bit count");
endmodule
bind ecg_frame_master_serial_port ecg_port_props u_props (.core_clk(core_clk), .resetn(resetn),
  .highPerfMode(highPerfMode), .perWordSelectOption(perWordSelectOption), .frameBusy(frameBusy),
  .port_chip_select_n(port_chip_select_n), .port_serial_clock(port_serial_clock),
  .port_serial_data_out(port_serial_data_out));

// ### verification/pace_logic_model.sv
// Purpose: receiving logic on the far side of the port
// Assumes: data sampled on falling serial clock while selected
// Notes: a partial word is dropped when select rises
`timescale 1ns/10ps
module pace_logic_model (
  input  wire        port_chip_select_n,
  input  wire        port_serial_clock,
  input  wire        port_serial_data_out,
  output reg  [15:0] rxWord,
  output reg         rxToggle
);
  reg [15:0] shiftReg;
  reg [4:0]  bitCnt;
  initial begin
    rxWord = 16'h0000;
    rxToggle = 1'b0;
    bitCnt = 5'h00;
  end
  always @(negedge port_serial_clock or posedge port_chip_select_n) begin
    if (port_chip_select_n) begin
      bitCnt = 5'h00;
    end else begin
      shiftReg = {shiftReg[14:0], port_serial_data_out};
      bitCnt = bitCnt + 5'h01;
      if (bitCnt == 5'h10) begin
        rxWord = shiftReg;
        rxToggle = !rxToggle;
        bitCnt = 5'h00;
      end
    end
  end
endmodule

// ### verification/tb.sv
// Purpose: frames of random words in both select modes
// Assumes: mode bit dropped once the last wanted frame has started
// Notes: words are checked against a queue in send order; one frame is cut by reset
`timescale 1ns/10ps
module tb;
  reg        core_clk, resetn, highPerfMode, perWordSelectOption, wordWrite, seenBusy;
  reg [2:0]  wordIndex;
  reg [15:0] wordData;
  reg [31:0] seed;
  reg [15:0] expQ[$];
  wire       csN, sclk, sdo, frameBusy, rxToggle;
  wire [15:0] rxWord;
  integer    miscompares, comparisons, i, f, w;
  ecg_frame_master_serial_port u_dut (.core_clk(core_clk), .resetn(resetn), .highPerfMode(highPerfMode),
    .perWordSelectOption(perWordSelectOption), .wordWrite(wordWrite), .wordIndex(wordIndex),
    .wordData(wordData), .port_chip_select_n(csN), .port_serial_clock(sclk),
    .port_serial_data_out(sdo), .frameBusy(frameBusy));
  pace_logic_model u_rx (.port_chip_select_n(csN), .port_serial_clock(sclk),
    .port_serial_data_out(sdo), .rxWord(rxWord), .rxToggle(rxToggle));
  function [31:0] xorshift(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xorshift = x ^ (x << 5);
    end
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task wait_busy(input level);
    begin
      i = 0;
      while (frameBusy !== level && i < 3000) begin
        @(negedge core_clk);
        i = i + 1;
      end
      check({15'h0000, frameBusy}, {15'h0000, level});
    end
  endtask
  // mode 0: one frame; 1: mode bit kept up for two frames; 2: reset cuts the frame
  task send_frame(input perWord, input [1:0] mode);
    begin
      @(posedge core_clk);
      perWordSelectOption <= perWord;
      for (w = 0; w < 7; w = w + 1) begin
        seed = xorshift(seed);
        wordWrite <= 1'b1;
        wordIndex <= w[2:0];
        wordData <= seed[15:0];
        expQ.push_back(seed[15:0]);
        @(posedge core_clk);
      end
      // the merged tick restarts the same stored words right after the gap
      if (mode == 2'h1) begin
        for (w = 0; w < 7; w = w + 1) expQ.push_back(expQ[expQ.size() - 7]);
      end
      wordWrite <= 1'b0;
      highPerfMode <= 1'b1;
      wait_busy(1'b1);
      if (mode == 2'h1) begin
        wait_busy(1'b0);
        wait_busy(1'b1);
      end
      if (mode == 2'h2) begin
        // reset lands in the second word; the model drops the partial word
        repeat (40) @(posedge core_clk);
        resetn <= 1'b0;
        highPerfMode <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        check({12'h000, csN, sclk, sdo, frameBusy}, 16'h000C);
        expQ.delete();
        @(posedge core_clk);
        resetn <= 1'b1;
      end else begin
        @(posedge core_clk);
        highPerfMode <= 1'b0;
      end
      wait_busy(1'b0);
      seenBusy = 1'b0;
      repeat (200) begin
        @(negedge core_clk);
        seenBusy = seenBusy | frameBusy;
      end
      check({15'h0000, seenBusy}, 16'h0000);
      check(16'(expQ.size()), 16'h0000);
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    resetn = 1'b0;
    highPerfMode = 1'b0;
    perWordSelectOption = 1'b0;
    wordWrite = 1'b0;
    wordIndex = 3'h0;
    wordData = 16'h0000;
    seed = 32'hA336;
    miscompares = 0;
    comparisons = 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    for (f = 0; f < 4; f = f + 1) send_frame(f[1], {1'b0, f[0]});
    send_frame(1'b0, 2'h2);
    final_report;
  end
  initial begin
    @(posedge resetn);
    forever begin
      @(rxToggle);
      if (expQ.size() == 0) check(16'h0001, 16'h0000);
      else check(rxWord, expQ.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares = miscompares + 1;
    final_report;
  end
endmodule
